/* File: debug_host.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Debug host model: drives the test port, the test clock stands still between scans.
module debug_host (
  // Test port pins.
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o,
  input  wire logic tdo_i
);
  // Idle levels before the first scan.
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // One 125 ns test clock: inputs move after the fall, the output is read after the rise.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    #2 tms_o = tms;
    tdi_o = tdi;
    #60.5 tck_o = 1'b1;
    #2 tdo = tdo_i;
    #60.5 tck_o = 1'b0;
  endtask : step
  // Five rises with mode-select high, then one low, so the port idles whatever its state.
  task automatic reset();
    logic t;
    repeat (5) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask : reset
  // Whole scan from idle: bit 0 of din is shifted first, the last bit leaves with tms high.
  task automatic scan(input logic ir, input int n, input logic [37:0] din,
                      output logic [37:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b0, t);
    if (ir) step(1'b1, 1'b0, t);
    repeat (2) step(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask : scan
endmodule : debug_host
`default_nettype wire

/* File: debug_scan_chains.sv */
`timescale 1ns/100ps
`default_nettype none
module debug_scan_chains
  import debug_scan_pkg::*;
#(
  parameter int CTRL_W    = 8,  // Width of the core control signal group.
  parameter int BUF_DEPTH = 2   // Depth of the chain 1 word buffer.
) (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // Test access port pins.
  input  wire logic                tck_i,
  input  wire logic                tms_i,
  input  wire logic                tdi_i,
  output var  logic                tdo_o,
  output var  logic                tdo_oe_o,
  // Core side, same clock.
  input  wire logic [DATA_W-1:0]   core_data_i,
  input  wire logic [CTRL_W-1:0]   core_ctrl_i,
  input  wire logic [ADDR_W-1:0]   core_addr_i,
  // Chain 0 cells and test modes.
  output var  logic [DATA_W-1:0]   test_data_o,
  output var  logic [CTRL_W-1:0]   test_ctrl_o,
  output var  logic [ADDR_W-1:0]   test_addr_o,
  output var  logic                intest_o,
  output var  logic                extest_o,
  // Buffered chain 1 words toward the core.
  output var  logic                word_valid_o,
  output var  logic [DATA_W-1:0]   word_data_o,
  output var  logic                word_bp_o,
  input  wire logic                word_ready_i,
  output var  logic                word_ready_o,
  // Watchpoint halt request.
  output var  logic                breakpoint_request_o
);
  // ==========================================================================
  // Local widths and declarations.
  // ==========================================================================
  localparam int C0_LEN = DATA_W + CTRL_W + ADDR_W;  // Chain 0 length.
  localparam int PW     = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;  // Pointer width.
  logic [2:0]            tck_s_r, tms_s_r, tdi_s_r;  // Synchronisers, bit 2 is the edge history.
  logic                  tck_rise, tck_fall;         // One-cycle edge pulses.
  tap_state_t            st_r, st_nxt;               // Controller state.
  logic [IR_W-1:0]       ir_sh_r, ir_r;              // Instruction shift and hold.
  logic [SEL_W-1:0]      sel_sh_r, sel_r;            // Chain-select shift and hold.
  logic                  byp_r;                      // Bypass bit.
  logic [C0_LEN-1:0]     sr0_r, cap0;                // Chain 0 cells, capture image.
  logic [CHAIN1_LEN-1:0] sr1_r, cap1;                // Chain 1 cells, capture image.
  logic [CHAIN2_LEN-1:0] sr2_r;                      // Chain 2 cells.
  logic                  use_sel, use_c0, use_c1, use_c2;  // Data register connection.
  logic                  dr_out;                     // Serial output of connected register.
  logic [RADDR_W-1:0]    rd_addr_r;                  // Watch register latched for reading.
  logic [DATA_W-1:0]     rd_data;                    // Watch register read value.
  logic [WP_UNITS-1:0]   en_r, hit_r, match;         // Enables, sticky hits, live match.
  logic [ADDR_W-1:0]     av_r [WP_UNITS];            // Address values.
  logic [ADDR_W-1:0]     am_r [WP_UNITS];            // Address masks.
  logic [DATA_W-1:0]     dv_r [WP_UNITS];            // Data values.
  logic [DATA_W-1:0]     dm_r [WP_UNITS];            // Data masks.
  logic [CTRL_W-1:0]     cv_r [WP_UNITS];            // Control values.
  logic [CTRL_W-1:0]     cm_r [WP_UNITS];            // Control masks.
  logic [CHAIN1_LEN-1:0] buf_r [BUF_DEPTH];          // Word buffer storage.
  logic [PW-1:0]         wp_r, rp_r;                 // Buffer pointers.
  logic [PW:0]           cnt_r, cnt_nxt;             // Buffer fill level.
  logic                  push, pop;                  // Buffer strobes.
  logic [2:0]            rst_cnt_r;                  // Helper: rises with mode-select high.

  // ==========================================================================
  // Pin synchronisers and edge detection.
  // ==========================================================================
  // Pins come from the host's domain; only bits 1 and 2 are read by logic.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tck_s_r <= 3'h0;
      tms_s_r <= 3'h7;
      tdi_s_r <= 3'h0;
    end else begin
      tck_s_r <= {tck_s_r[1:0], tck_i};
      tms_s_r <= {tms_s_r[1:0], tms_i};
      tdi_s_r <= {tdi_s_r[1:0], tdi_i};
    end
  end
  // Mode-select and data are delayed like the clock, so a rise sees stable values.
  assign tck_rise = tck_s_r[1] & ~tck_s_r[2];
  assign tck_fall = ~tck_s_r[1] & tck_s_r[2];

  // ==========================================================================
  // Controller state machine.
  // ==========================================================================
  // Five rises with mode-select high reach reset from any state.
  always_comb begin
    unique case (st_r)
      ST_TLR:    st_nxt = tms_s_r[2] ? ST_TLR    : ST_RTI;
      ST_RTI:    st_nxt = tms_s_r[2] ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: st_nxt = tms_s_r[2] ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_nxt = tms_s_r[2] ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  st_nxt = tms_s_r[2] ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: st_nxt = tms_s_r[2] ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  st_nxt = tms_s_r[2] ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: st_nxt = tms_s_r[2] ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: st_nxt = tms_s_r[2] ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: st_nxt = tms_s_r[2] ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: st_nxt = tms_s_r[2] ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  st_nxt = tms_s_r[2] ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: st_nxt = tms_s_r[2] ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  st_nxt = tms_s_r[2] ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: st_nxt = tms_s_r[2] ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: st_nxt = tms_s_r[2] ? ST_SEL_DR : ST_RTI;
    endcase
  end
  // The state moves only on a test clock rise.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) st_r <= ST_TLR;
    else if (tck_rise) st_r <= st_nxt;
  end

  // ==========================================================================
  // Instruction and chain-select registers.
  // ==========================================================================
  // Instruction shifts least significant bit first and takes effect at update.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_sh_r <= IR_CAPTURE;
      ir_r    <= INSN_BYPASS;
    end else if (tck_rise) begin
      if (st_r == ST_TLR) ir_r <= INSN_BYPASS;
      if (st_r == ST_CAP_IR) ir_sh_r <= IR_CAPTURE;
      else if (st_r == ST_SH_IR) ir_sh_r <= {tdi_s_r[2], ir_sh_r[IR_W-1:1]};
      if (st_r == ST_UPD_IR) ir_r <= ir_sh_r;
    end
  end
  // Data register routing: only the selected chain is ever connected.
  assign use_sel = (ir_r == INSN_SCAN_SEL);
  assign use_c0  = (ir_r == INSN_INTEST || ir_r == INSN_EXTEST) && sel_r == CHAIN_PERIPH;
  assign use_c1  = (ir_r == INSN_INTEST) && sel_r == CHAIN_DEBUG;
  assign use_c2  = (ir_r == INSN_INTEST) && sel_r == CHAIN_WATCH;
  // The select register is written by the host only under the select instruction.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_sh_r <= CHAIN_PERIPH;
      sel_r    <= CHAIN_PERIPH;
      byp_r    <= 1'b0;
    end else if (tck_rise) begin
      if (st_r == ST_TLR) sel_r <= CHAIN_PERIPH;
      if (st_r == ST_CAP_DR) byp_r <= 1'b0;
      else if (st_r == ST_SH_DR) byp_r <= tdi_s_r[2];
      if (use_sel && st_r == ST_CAP_DR) sel_sh_r <= sel_r;
      else if (use_sel && st_r == ST_SH_DR) sel_sh_r <= {tdi_s_r[2], sel_sh_r[SEL_W-1:1]};
      if (use_sel && st_r == ST_UPD_DR) sel_r <= sel_sh_r;
    end
  end

  // ==========================================================================
  // Scan chains.
  // ==========================================================================
  // Bit 0 of each chain sits at the serial output, the top bit at the input.
  for (genvar i = 0; i < DATA_W; i++) begin : g_data_order
    assign cap0[C0_LEN-1-i] = core_data_i[i];
    assign cap1[CHAIN1_LEN-1-i] = core_data_i[i];
    assign test_data_o[i] = sr0_r[C0_LEN-1-i];
    assign word_data_o[i] = buf_r[rp_r][CHAIN1_LEN-1-i];
  end
  assign cap0[ADDR_W+CTRL_W-1:ADDR_W] = core_ctrl_i;
  assign cap0[ADDR_W-1:0] = core_addr_i;  // Address 31 downward ends at the output.
  assign cap1[0] = breakpoint_request_o;
  // No update stage: cells drive the test buses while they shift.
  // Surrounding logic must qualify these buses with the test modes.
  assign test_ctrl_o = sr0_r[ADDR_W+CTRL_W-1:ADDR_W];
  assign test_addr_o = sr0_r[ADDR_W-1:0];
  assign word_bp_o   = buf_r[rp_r][0];
  // Each chain captures and shifts only while it is the connected one.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sr0_r <= '0;
      sr1_r <= '0;
      sr2_r <= '0;
    end else if (tck_rise) begin
      if (use_c0 && st_r == ST_CAP_DR) sr0_r <= cap0;
      else if (use_c0 && st_r == ST_SH_DR) sr0_r <= {tdi_s_r[2], sr0_r[C0_LEN-1:1]};
      if (use_c1 && st_r == ST_CAP_DR) sr1_r <= cap1;
      else if (use_c1 && st_r == ST_SH_DR) sr1_r <= {tdi_s_r[2], sr1_r[CHAIN1_LEN-1:1]};
      if (use_c2 && st_r == ST_CAP_DR) sr2_r[DATA_W-1:0] <= rd_data;
      else if (use_c2 && st_r == ST_SH_DR) sr2_r <= {tdi_s_r[2], sr2_r[CHAIN2_LEN-1:1]};
    end
  end
  // Test mode levels follow the active instruction.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      intest_o <= 1'b0;
      extest_o <= 1'b0;
    end else begin
      intest_o <= (ir_r == INSN_INTEST);
      extest_o <= (ir_r == INSN_EXTEST);
    end
  end

  // ==========================================================================
  // Serial output.
  // ==========================================================================
  always_comb begin
    if (use_sel) dr_out = sel_sh_r[0];
    else if (use_c0) dr_out = sr0_r[0];
    else if (use_c1) dr_out = sr1_r[0];
    else if (use_c2) dr_out = sr2_r[0];
    else dr_out = byp_r;
  end
  // The output moves on the falling edge so the host reads it safely after a rise.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_o <= (st_r == ST_SH_DR) || (st_r == ST_SH_IR);
      tdo_o    <= (st_r == ST_SH_IR) ? ir_sh_r[0] : (st_r == ST_SH_DR) ? dr_out : 1'b0;
    end
  end

  // ==========================================================================
  // Watch unit registers behind chain 2.
  // ==========================================================================
  // Units sit at base (unit + 1) * 8, the control register at zero.
  always_comb begin
    rd_data = '0;
    if (rd_addr_r == WREG_CTRL) begin
      rd_data[CTRL_EN_LSB +: WP_UNITS]  = en_r;
      rd_data[STAT_HIT_LSB +: WP_UNITS] = hit_r;
      rd_data[STAT_FULL]                = ~word_ready_o;
    end else begin
      for (int u = 0; u < WP_UNITS; u++) begin
        if (rd_addr_r[RADDR_W-1:3] == 2'(u + 1)) begin
          unique case (rd_addr_r[2:0])
            {1'b0, WOFS_AV}: rd_data = av_r[u];
            {1'b0, WOFS_AM}: rd_data = am_r[u];
            {1'b0, WOFS_DV}: rd_data = dv_r[u];
            {1'b0, WOFS_DM}: rd_data = dm_r[u];
            WOFS_CV:         rd_data[CTRL_W-1:0] = cv_r[u];
            WOFS_CM:         rd_data[CTRL_W-1:0] = cm_r[u];
            default:         rd_data = '0;
          endcase
        end
      end
    end
  end
  // Update of chain 2 always latches the read address, and also writes when the direction flag is set.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_addr_r <= WREG_CTRL;
      en_r      <= '0;
      for (int u = 0; u < WP_UNITS; u++) begin
        av_r[u] <= '0; am_r[u] <= '1; dv_r[u] <= '0;
        dm_r[u] <= '1; cv_r[u] <= '0; cm_r[u] <= '1;
      end
    end else if (tck_rise && use_c2 && st_r == ST_UPD_DR) begin
      rd_addr_r <= sr2_r[C2_ADDR_LSB +: RADDR_W];
      if (sr2_r[C2_RW_BIT] && sr2_r[C2_ADDR_LSB +: RADDR_W] == WREG_CTRL)
        en_r <= sr2_r[CTRL_EN_LSB +: WP_UNITS];
      for (int u = 0; u < WP_UNITS; u++) begin
        if (sr2_r[C2_RW_BIT] && sr2_r[C2_ADDR_LSB+3 +: 2] == 2'(u + 1)) begin
          unique case (sr2_r[C2_ADDR_LSB +: 3])
            {1'b0, WOFS_AV}: av_r[u] <= sr2_r[DATA_W-1:0];
            {1'b0, WOFS_AM}: am_r[u] <= sr2_r[DATA_W-1:0];
            {1'b0, WOFS_DV}: dv_r[u] <= sr2_r[DATA_W-1:0];
            {1'b0, WOFS_DM}: dm_r[u] <= sr2_r[DATA_W-1:0];
            WOFS_CV:         cv_r[u] <= sr2_r[CTRL_W-1:0];
            WOFS_CM:         cm_r[u] <= sr2_r[CTRL_W-1:0];
            default:         ;
          endcase
        end
      end
    end
  end
  // A set mask bit drops that bit from the compare.
  for (genvar u = 0; u < WP_UNITS; u++) begin : g_watch
    assign match[u] = ~|((core_addr_i ^ av_r[u]) & ~am_r[u])
                    & ~|((core_data_i ^ dv_r[u]) & ~dm_r[u])
                    & ~|((core_ctrl_i ^ cv_r[u]) & ~cm_r[u]);
  end
  // Hits are sticky; a write of the control register cannot lose a new hit.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      breakpoint_request_o <= 1'b0;
      hit_r                <= '0;
    end else begin
      breakpoint_request_o <= |(en_r & match);
      if (tck_rise && use_c2 && st_r == ST_UPD_DR && sr2_r[C2_RW_BIT]
          && sr2_r[C2_ADDR_LSB +: RADDR_W] == WREG_CTRL)
        hit_r <= (en_r & match);
      else
        hit_r <= hit_r | (en_r & match);
    end
  end

  // ==========================================================================
  // Chain 1 word buffer toward the core.
  // ==========================================================================
  // Words reach the core only through this buffer, so shifting never disturbs it.
  // A full buffer refuses the update; the host sees the full flag in status.
  assign push    = tck_rise && use_c1 && st_r == ST_UPD_DR && word_ready_o;
  assign pop     = word_valid_o && word_ready_i;
  assign cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= '0; rp_r <= '0; cnt_r <= '0;
      word_valid_o <= 1'b0;
      word_ready_o <= 1'b1;
      for (int k = 0; k < BUF_DEPTH; k++) buf_r[k] <= '0;
    end else begin
      if (push) buf_r[wp_r] <= sr1_r;
      if (push) wp_r <= (wp_r == PW'(BUF_DEPTH-1)) ? '0 : wp_r + PW'(1);
      if (pop) rp_r <= (rp_r == PW'(BUF_DEPTH-1)) ? '0 : rp_r + PW'(1);
      cnt_r        <= cnt_nxt;
      word_valid_o <= (cnt_nxt != '0);
      word_ready_o <= (cnt_nxt != (PW+1)'(BUF_DEPTH));
    end
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  // Helper: counts consecutive rises with mode-select high, saturating.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_cnt_r <= 3'h0;
    else if (tck_rise) rst_cnt_r <= !tms_s_r[2] ? 3'h0 : (rst_cnt_r == 3'h7) ? 3'h7 : rst_cnt_r + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_tap_soft_reset: assert property (rst_cnt_r >= 3'(TAP_RESET_EDGES) |-> st_r == ST_TLR)
    else $error("Five mode-select-high rises did not reset the port.");
  a_state_on_rise: assert property ($changed(st_r) |-> $past(tck_rise))
    else $error("Controller state moved without a test clock rise.");
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> $past(tck_fall))
    else $error("Serial output changed away from a falling edge.");
  a_select_write: assert property (tck_rise && use_sel && st_r == ST_UPD_DR
                                   |=> sel_r == $past(sel_sh_r))
    else $error("Chain-select register missed its update.");
  a_one_chain_only: assert property ($onehot0({use_sel, use_c0, use_c1, use_c2}))
    else $error("More than one scan path connected.");
  a_watch_halt: assert property (|(en_r & match) |=> breakpoint_request_o)
    else $error("Enabled watch match did not raise the breakpoint request.");
  a_no_false_halt: assert property (!(|(en_r & match)) |=> !breakpoint_request_o)
    else $error("Breakpoint request without an enabled match.");
  a_masked_unit: assert property (en_r[0] && am_r[0] == '1 && dm_r[0] == '1
                                  && cm_r[0] == '1 |=> breakpoint_request_o)
    else $error("Fully masked enabled unit failed to match.");
  a_chain2_ctrl: assert property (tck_rise && use_c2 && st_r == ST_UPD_DR && sr2_r[C2_RW_BIT]
                  && sr2_r[C2_ADDR_LSB +: RADDR_W] == WREG_CTRL
                  |=> en_r == $past(sr2_r[CTRL_EN_LSB +: WP_UNITS]))
    else $error("Chain 2 write of the control register was lost.");
  // Ready is registered from the fill level, so in a full cycle it is already low and blocks the push.
  a_buffer_full: assert property (cnt_r == (PW+1)'(BUF_DEPTH) |-> !push && !word_ready_o)
    else $error("Word pushed into a full buffer.");
  a_mode_levels: assert property (ir_r == INSN_INTEST |=> intest_o && !extest_o)
    else $error("Core test mode level does not follow the instruction.");
endmodule : debug_scan_chains
`default_nettype wire

/* File: debug_scan_chains_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Bench: the host scans the chains while the core side drains words and moves the buses.
module debug_scan_chains_tb;
  import debug_scan_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, rdy = 1'b0, tck, tms, tdi, tdo, vld, bp, wbp, rdo, ite, ext, oe;
  logic [31:0] cd = '0, ca = '0, wd, ta;
  logic [7:0]  cc = '0;
  int          err_total = 0, checked = 0;
  always #5 clk_i = ~clk_i;
  debug_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  debug_scan_chains dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(oe), .core_data_i(cd), .core_ctrl_i(cc),
    .core_addr_i(ca), .test_data_o(), .test_ctrl_o(), .test_addr_o(ta), .intest_o(ite),
    .extest_o(ext), .word_valid_o(vld), .word_data_o(wd), .word_bp_o(wbp),
    .word_ready_i(rdy), .word_ready_o(rdo), .breakpoint_request_o(bp));
  // Compare of any result, zero-extended to 38 bits, the chain 2 length.
  task automatic chk(input logic [37:0] g, input logic [37:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Connects one chain under the core-test instruction.
  task automatic pick(input logic [3:0] s);
    logic [37:0] q;
    host.reset();
    host.scan(1'b1, IR_W, 38'(INSN_SCAN_SEL), q);
    host.scan(1'b0, SEL_W, 38'(s), q);
    host.scan(1'b1, IR_W, 38'(INSN_INTEST), q);
    chk(ite, 1'b1);
  endtask : pick
  // Chain 1 word: the breakpoint bit goes in first, then data 31 down to 0.
  task automatic w1(input logic [31:0] d, input logic b);
    logic [37:0] q;
    logic [31:0] r;
    r = {<<{d}};
    host.scan(1'b0, CHAIN1_LEN, {5'h0, r, b}, q);
  endtask : w1
  // Chain 0 under board test: address 0 leaves first, then the control group.
  task automatic t_chain0();
    logic [37:0] q;
    pick(CHAIN_PERIPH);
    host.scan(1'b1, IR_W, 38'(INSN_EXTEST), q);
    chk({ext, ite}, 2'h2);
    @(posedge clk_i);
    #1 ca = 32'h8000_0001;
    cc = 8'h5a;
    host.scan(1'b0, 38, 38'h0, q);
    chk(q, {6'h1a, 32'h8000_0001});
    // Test buses are read only once the scan is over, as outside logic must.
    chk(ta, 32'h1);
    chk(oe, 1'b0);
  endtask : t_chain0
  // Chain 2 access: direction flag, register address, data.
  task automatic w2(input logic rw, input logic [4:0] a, input logic [31:0] d,
                    output logic [37:0] q);
    host.scan(1'b0, CHAIN2_LEN, {rw, a, d}, q);
  endtask : w2
  // One word is taken by the core, then the head is allowed to settle.
  task automatic pop();
    @(posedge clk_i);
    #1 rdy = 1'b1;
    @(posedge clk_i);
    #1 rdy = 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : pop
  // Two words fill the buffer while the core stalls; a third is refused.
  task automatic t_chain1();
    pick(CHAIN_DEBUG);
    w1(32'h1234_5678, 1'b1);
    w1(32'h0f0f_a5a5, 1'b0);
    chk({vld, rdo}, 2'h2);
    w1(32'hffff_ffff, 1'b1);
    chk({wbp, wd}, {1'b1, 32'h1234_5678});
    pop();
    chk({vld, wbp, wd}, {2'h2, 32'h0f0f_a5a5});
    pop();
    chk({vld, rdo}, 2'h1);
  endtask : t_chain1
  // Moves the core address and lets the registered request follow.
  task automatic bus(input logic [31:0] a, input logic e);
    @(posedge clk_i);
    #1 ca = a;
    repeat (3) @(posedge clk_i);
    chk(bp, e);
  endtask : bus
  // Unit 0 (base 8) first matches anything while fully masked, then one address, then 0x104 as well with address bit 2 masked.
  task automatic t_watch();
    logic [37:0] q;
    pick(CHAIN_WATCH);
    w2(1'b1, WREG_CTRL, 32'h1, q);
    bus(32'h0, 1'b1);
    w2(1'b1, {2'h1, 1'b0, WOFS_AV}, 32'h100, q);
    w2(1'b1, {2'h1, 1'b0, WOFS_AM}, 32'h0, q);
    bus(32'h100, 1'b1);
    bus(32'h104, 1'b0);
    w2(1'b1, {2'h1, 1'b0, WOFS_AM}, 32'h4, q);
    bus(32'h104, 1'b1);
    w2(1'b0, WREG_CTRL, 32'h0, q);
    w2(1'b0, WREG_CTRL, 32'h0, q);
    chk(q[4:0], 5'h05);
    host.reset();
    chk(ite, 1'b0);
  endtask : t_watch
  // Counts, verdict and end of run.
  task automatic report_and_stop();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // Main sequence after a two-cycle reset.
  initial begin
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    t_chain0();
    t_chain1();
    t_watch();
    report_and_stop();
  end
  // Watchdog well beyond the roughly 67 us the scans need.
  initial begin
    #300000 err_total++;
    report_and_stop();
  end
endmodule : debug_scan_chains_tb
`default_nettype wire

/* File: debug_scan_pkg.sv */
// ============================================================================
// Shared constants for the debug scan-chain block.
// ============================================================================
package debug_scan_pkg;
  // Widths of the core buses and of the serial registers.
  localparam int DATA_W     = 32;  // Core data bus width.
  localparam int ADDR_W     = 32;  // Core address bus width.
  localparam int CHAIN1_LEN = 33;  // Data bus plus breakpoint request bit.
  localparam int CHAIN2_LEN = 38;  // Direction flag, register address, data.
  localparam int RADDR_W    = 5;   // Watch register address width.
  localparam int IR_W       = 4;   // Instruction register width.
  localparam int SEL_W      = 4;   // Chain-select register width.
  localparam int WP_UNITS   = 2;   // Number of watchpoint units.
  // Bit positions inside chain 2.
  localparam int C2_RW_BIT   = 37;  // Direction flag, nearest the serial input.
  localparam int C2_ADDR_LSB = 32;  // Register address field low bit.
  // Instruction encodings.
  localparam logic [IR_W-1:0] INSN_EXTEST   = 4'h0;  // Board-level test of chain 0.
  localparam logic [IR_W-1:0] INSN_SCAN_SEL = 4'h2;  // Connects the chain-select register.
  localparam logic [IR_W-1:0] INSN_RESTART  = 4'h4;  // Behaves as bypass.
  localparam logic [IR_W-1:0] INSN_INTEST   = 4'hc;  // Core test through selected chain.
  localparam logic [IR_W-1:0] INSN_BYPASS   = 4'hf;  // One-bit bypass, reset value.
  localparam logic [IR_W-1:0] IR_CAPTURE    = 4'h1;  // Pattern loaded in capture-IR.
  // Chain numbers held in the chain-select register.
  localparam logic [SEL_W-1:0] CHAIN_PERIPH = 4'h0;  // Whole core periphery.
  localparam logic [SEL_W-1:0] CHAIN_DEBUG  = 4'h1;  // Data bus and breakpoint bit.
  localparam logic [SEL_W-1:0] CHAIN_WATCH  = 4'h2;  // Watch unit registers.
  // Watch unit register map reached through chain 2.
  localparam logic [RADDR_W-1:0] WREG_CTRL = 5'h00;  // Control and status register.
  localparam logic [1:0] WOFS_AV = 2'h0;  // Address value, at base plus 0.
  localparam logic [1:0] WOFS_AM = 2'h1;  // Address mask, one bit ignores a bit.
  localparam logic [1:0] WOFS_DV = 2'h2;  // Data value.
  localparam logic [1:0] WOFS_DM = 2'h3;  // Data mask.
  localparam logic [2:0] WOFS_CV = 3'h4;  // Control value.
  localparam logic [2:0] WOFS_CM = 3'h5;  // Control mask.
  // Control and status register fields.
  localparam int CTRL_EN_LSB  = 0;  // Unit enables, one bit per unit.
  localparam int STAT_HIT_LSB = 2;  // Sticky hit flags, one bit per unit.
  localparam int STAT_FULL    = 4;  // Word buffer full.
  // Host-driven port reset.
  localparam int TAP_RESET_EDGES = 5;  // Rising edges with mode-select high.
  // Test access port controller states.
  typedef enum logic [3:0] {
    ST_TLR = 4'hf, ST_RTI = 4'hc, ST_SEL_DR = 4'h7, ST_CAP_DR = 4'h6,
    ST_SH_DR = 4'h2, ST_EX1_DR = 4'h1, ST_PA_DR = 4'h3, ST_EX2_DR = 4'h0,
    ST_UPD_DR = 4'h5, ST_SEL_IR = 4'h4, ST_CAP_IR = 4'he, ST_SH_IR = 4'ha,
    ST_EX1_IR = 4'h9, ST_PA_IR = 4'hb, ST_EX2_IR = 4'h8, ST_UPD_IR = 4'hd
  } tap_state_t;
endpackage : debug_scan_pkg
